// File: verilog/asfc_top.sv
// Serial frame control and alternate status registers with line routing.
// Assumes an APB master on clk_sys_i; the serial core sits outside.
// Summary of operation
// [R1] Loop select detaches receive pin
// [R2] Software enables transmitter and receiver for loop
// [R3] Source bit: internal loop or single wire
// [R4] Stop-in-wait disables interface in wait
// [R5] Length bit selects eight or nine bits
// [R6] Wake bit: idle line or address mark
// [R7] Idle type one counts after stop
// [R8] Idle type zero counts after start
// [R9] Parity enable generates and checks parity
// [R10] Parity type: zero even, one odd
// [R11] Frame control at 0x2 when map is 0
// [R12] Alternate status at 0x0 when map is 1
// [R13] Active edge flag per polarity, write-one-clear
// [R14] Bit error value records sampled level
// [R15] Bit error flag on mismatch, write-one-clear
// [R16] Break flag when enabled, write-one-clear
// [R17] Zero writes keep flags; value bit read-only
// [R18] Map select bit in status register two
// [R19] Bit error mode picks sample tick
// [R20] Break enable gates break detection
module asfc_top import asfc_pkg::*; #(
  parameter int TICK_DIV = ASFC_DEF_TICK_DIV
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial pins and core
  input wire logic rxd_i,
  input wire logic core_txd_i,
  input wire logic core_txd_oe_i,
  input wire logic wait_mode_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic core_rxd_o,
  // Format controls to the core
  output logic nine_bits_o,
  output logic wake_addr_mark_o,
  output logic idle_after_stop_o,
  output logic parity_enable_o,
  output logic parity_odd_o,
  output logic core_enable_o,
  // Interrupt requests of the status flags
  output logic bit_error_irq_o,
  output logic break_irq_o,
  output logic rx_edge_irq_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] frame_control_q, frame_control_d;
  logic [7:0] status_q, status_d;
  logic [7:0] alt_ctl1_q, alt_ctl1_d;
  logic [7:0] alt_ctl2_q, alt_ctl2_d;
  logic [7:0] sr2_q, sr2_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [2:0] rx_sync_q, rx_sync_d;
  logic rx_clean_q, rx_clean_d;
  logic wr_acc, rd_acc, alternate_map_select, hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic loop_on, rx_routed;
  asfc_line_if ln ();
  asfc_line_mon #(.TICK_DIV(TICK_DIV)) u_mon (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ln(ln)
  );
  // ----------------------------------------
  // Line routing
  // ----------------------------------------
  always_comb begin
    loop_on = frame_control_q[ASFC_FC_LOOP];
    rx_routed = rx_clean_q; // R1
    if (loop_on) begin
      // Loop only meaningful with both halves enabled in the core; single wire
      // reads the transmit pin, which carries the transmitter output here
      rx_routed = core_txd_i; // R3
    end
    rx_sync_d = {rx_sync_q[1:0], rxd_i};
    // Pin value changes only when the last two stages agree, filtering one-cycle glitches
    rx_clean_d = (rx_sync_q[2] == rx_sync_q[1]) ? rx_sync_q[2] : rx_clean_q;
  end
  // Single wire: transmit pin carries the line; internal loop keeps it idle high
  assign txd_o = (loop_on && !frame_control_q[ASFC_FC_RECEIVER_SOURCE]) ? 1'b1 : core_txd_i; // R3
  assign txd_oe_o = core_txd_oe_i;
  assign core_rxd_o = rx_routed;
  assign core_enable_o = !(frame_control_q[ASFC_FC_SWAI] && wait_mode_i); // R4
  assign nine_bits_o = frame_control_q[ASFC_FC_NINE]; // R5
  assign wake_addr_mark_o = frame_control_q[ASFC_FC_WAKE]; // R6
  assign idle_after_stop_o = frame_control_q[ASFC_FC_ILT]; // R7 R8
  assign parity_enable_o = frame_control_q[ASFC_FC_PEN]; // R9
  assign parity_odd_o = frame_control_q[ASFC_FC_PODD]; // R10
  assign ln.rx_level = rx_routed;
  assign ln.tx_level = core_txd_i;
  assign ln.polarity = sr2_q[ASFC_SR2_RECEIVE_POLARITY];
  assign ln.brk_en = alt_ctl2_q[ASFC_AC2_BRK_EN]; // R20
  assign ln.berr_mode = alt_ctl2_q[ASFC_AC2_BIT_ERROR_MODE_LO+1:ASFC_AC2_BIT_ERROR_MODE_LO]; // R19
  assign ln.nine_bits = frame_control_q[ASFC_FC_NINE];
  assign ln.pen = frame_control_q[ASFC_FC_PEN];
  assign bit_error_irq_o = status_q[ASFC_ST_BERR] && alt_ctl1_q[ASFC_AC1_BERR_IE]; // R15
  assign break_irq_o = status_q[ASFC_ST_BRK] && alt_ctl1_q[ASFC_AC1_BRK_IE]; // R16
  assign rx_edge_irq_o = status_q[ASFC_ST_EDGE] && alt_ctl1_q[ASFC_AC1_EDGE_IE];
  // ----------------------------------------
  // APB access
  // ----------------------------------------
  assign pready_o = 1'b1;
  assign prdata_o = rdata_q;
  assign pslverr_o = err_q;
  always_comb begin
    alternate_map_select = sr2_q[ASFC_SR2_ALTERNATE_MAP_SELECT]; // R18
    idx = paddr_i[ASFC_ADDR_W+1:2];
    hit = (paddr_i[1:0] == 2'b00) && (paddr_i[31:ASFC_ADDR_W+2] == '0);
    wr_acc = psel_i && penable_i && pwrite_i && hit;
    rd_acc = psel_i && !penable_i && !pwrite_i;
    wbyte = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
    frame_control_d = frame_control_q;
    alt_ctl1_d = alt_ctl1_q;
    alt_ctl2_d = alt_ctl2_q;
    sr2_d = sr2_q;
    status_d = status_q;
    rbyte = 8'h00;
    err_d = err_q;
    // Writes land at the access edge, where the master samples pready high
    if (wr_acc && pstrb_i[0]) begin
      if (!alternate_map_select && idx == ASFC_IDX_FRAME_CONTROL) begin
        frame_control_d = wbyte; // R11
      end
      if (alternate_map_select && idx == ASFC_IDX_LINE_EVENT_STATUS) begin
        status_d[ASFC_ST_EDGE] = status_q[ASFC_ST_EDGE] && !wbyte[ASFC_ST_EDGE]; // R13 R17
        status_d[ASFC_ST_BERR] = status_q[ASFC_ST_BERR] && !wbyte[ASFC_ST_BERR]; // R15 R17
        status_d[ASFC_ST_BRK] = status_q[ASFC_ST_BRK] && !wbyte[ASFC_ST_BRK]; // R16 R17
      end
      if (alternate_map_select && idx == ASFC_IDX_ALT_CONTROL_ONE) begin
        alt_ctl1_d = wbyte & 8'h83;
      end
      if (alternate_map_select && idx == ASFC_IDX_ALT_CONTROL_TWO) begin
        alt_ctl2_d = wbyte & 8'h07;
      end
      if (idx == ASFC_IDX_STATUS_REGISTER_TWO) begin
        sr2_d = wbyte & 8'h90;
      end
    end
    // Hardware set wins over a same-cycle clear
    if (ln.edge_evt) begin
      status_d[ASFC_ST_EDGE] = 1'b1; // R13
    end
    if (ln.berr_evt && !status_d[ASFC_ST_BERR]) begin
      status_d[ASFC_ST_BIT_ERROR_VALUE] = ln.berr_val; // R14
    end
    if (ln.berr_evt) begin
      status_d[ASFC_ST_BERR] = 1'b1; // R15
    end
    if (ln.brk_evt) begin
      status_d[ASFC_ST_BRK] = 1'b1; // R16
    end
    if (!alternate_map_select && idx == ASFC_IDX_FRAME_CONTROL) begin
      rbyte = frame_control_q; // R11
    end else if (alternate_map_select && idx == ASFC_IDX_LINE_EVENT_STATUS) begin
      rbyte = status_q; // R12
    end else if (alternate_map_select && idx == ASFC_IDX_ALT_CONTROL_ONE) begin
      rbyte = alt_ctl1_q;
    end else if (alternate_map_select && idx == ASFC_IDX_ALT_CONTROL_TWO) begin
      rbyte = alt_ctl2_q;
    end else if (idx == ASFC_IDX_STATUS_REGISTER_TWO) begin
      rbyte = sr2_q;
    end
    // Bad addresses read zero so an alias never leaks a register
    rdata_d = rd_acc ? {24'h000000, hit ? rbyte : 8'h00} : rdata_q;
    if (psel_i && !penable_i) begin
      err_d = !hit;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_control_q <= ASFC_RST_BYTE;
      status_q <= ASFC_RST_BYTE;
      alt_ctl1_q <= ASFC_RST_BYTE;
      alt_ctl2_q <= ASFC_RST_BYTE;
      sr2_q <= ASFC_RST_BYTE;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
      rx_sync_q <= 3'h7;
      rx_clean_q <= 1'b1;
    end else begin
      frame_control_q <= frame_control_d;
      status_q <= status_d;
      alt_ctl1_q <= alt_ctl1_d;
      alt_ctl2_q <= alt_ctl2_d;
      sr2_q <= sr2_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      rx_sync_q <= rx_sync_d;
      rx_clean_q <= rx_clean_d;
    end
  end
endmodule : asfc_top

// File: verilog/asfc_pkg.sv
// Package for the serial frame control and alternate status block.
// Assumes an APB slave with 32-bit data and one byte register per word.
package asfc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ASFC_IDX_LINE_EVENT_STATUS = 8'h00;
  localparam logic [7:0] ASFC_IDX_FRAME_CONTROL = 8'h02;
  localparam logic [7:0] ASFC_IDX_ALT_CONTROL_ONE = 8'h01;
  localparam logic [7:0] ASFC_IDX_ALT_CONTROL_TWO = 8'h02;
  localparam logic [7:0] ASFC_IDX_STATUS_REGISTER_TWO = 8'h05;
  localparam int ASFC_ADDR_W = 8;
  // ----------------------------------------
  // Frame control fields
  // ----------------------------------------
  localparam int ASFC_FC_LOOP = 7;
  localparam int ASFC_FC_SWAI = 6;
  localparam int ASFC_FC_RECEIVER_SOURCE = 5;
  localparam int ASFC_FC_NINE = 4;
  localparam int ASFC_FC_WAKE = 3;
  localparam int ASFC_FC_ILT = 2;
  localparam int ASFC_FC_PEN = 1;
  localparam int ASFC_FC_PODD = 0;
  // ----------------------------------------
  // Line event status fields
  // ----------------------------------------
  localparam int ASFC_ST_EDGE = 7;
  localparam int ASFC_ST_BIT_ERROR_VALUE = 2;
  localparam int ASFC_ST_BERR = 1;
  localparam int ASFC_ST_BRK = 0;
  // Alternate control one / two, status register two
  localparam int ASFC_AC1_EDGE_IE = 7;
  localparam int ASFC_AC1_BERR_IE = 1;
  localparam int ASFC_AC1_BRK_IE = 0;
  localparam int ASFC_AC2_BIT_ERROR_MODE_LO = 1;
  localparam int ASFC_AC2_BRK_EN = 0;
  localparam int ASFC_SR2_ALTERNATE_MAP_SELECT = 7;
  localparam int ASFC_SR2_RECEIVE_POLARITY = 4;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] ASFC_RST_BYTE = 8'h00;
  localparam logic [3:0] ASFC_TICK_EARLY = 4'h8;
  localparam logic [3:0] ASFC_TICK_LATE = 4'hC;
  localparam logic [3:0] ASFC_BREAK_BITS = 4'hA;
  localparam logic [3:0] ASFC_TICKS_PER_BIT = 4'hF;
  localparam int ASFC_DEF_TICK_DIV = 4;
  typedef enum logic [1:0] {
    ASFC_BIT_ERROR_MODE_OFF = 2'b00,
    ASFC_BIT_ERROR_MODE_T9 = 2'b01,
    ASFC_BIT_ERROR_MODE_T13 = 2'b10,
    ASFC_BIT_ERROR_MODE_RSVD = 2'b11
  } asfc_bit_error_mode_t;
endpackage : asfc_pkg

// File: verilog/asfc_line_if.sv
// Carries routed line levels and sample strobes between line monitor and top.
// Assumes both ends run on the same system clock.
interface asfc_line_if;
  logic rx_level;
  logic tx_level;
  logic polarity;
  logic brk_en;
  logic [1:0] berr_mode;
  logic nine_bits;
  logic pen;
  logic edge_evt;
  logic berr_evt;
  logic berr_val;
  logic brk_evt;
  modport mon (input rx_level, tx_level, polarity, brk_en, berr_mode, nine_bits, pen,
               output edge_evt, berr_evt, berr_val, brk_evt);
  modport top (output rx_level, tx_level, polarity, brk_en, berr_mode, nine_bits, pen,
               input edge_evt, berr_evt, berr_val, brk_evt);
endinterface : asfc_line_if

// File: verilog/asfc_line_mon.sv
// Line monitor: active edge, bit error and break detection on the routed input.
// Assumes rx_level is already synchronised to clk_sys_i.
module asfc_line_mon import asfc_pkg::*; #(
  parameter int TICK_DIV = ASFC_DEF_TICK_DIV
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Line
  asfc_line_if.mon ln
);
  // Divider is eight bits wide; refuse what it cannot count
  if (TICK_DIV < 1 || TICK_DIV > 255) begin : g_bad_div
    $error("TICK_DIV out of range");
  end
  logic rx_prev_q, rx_prev_d;
  logic [7:0] div_q, div_d;
  logic [3:0] tick_q, tick_d;
  logic [3:0] low_bits_q, low_bits_d;
  logic tick_en;
  logic [3:0] stop_bits;
  always_comb begin
    tick_en = (div_q == 8'(TICK_DIV - 1));
    div_d = tick_en ? 8'h00 : div_q + 8'h01;
    tick_d = tick_en ? tick_q + 4'h1 : tick_q;
    rx_prev_d = ln.rx_level;
    // Break: a frame's worth of zeros, longer with nine bits or parity
    stop_bits = ASFC_BREAK_BITS + {3'b000, ln.nine_bits} + {3'b000, ln.pen};
    low_bits_d = low_bits_q;
    if (ln.rx_level) begin
      low_bits_d = 4'h0;
    end else if (tick_en && tick_q == ASFC_TICKS_PER_BIT && low_bits_q != 4'hF) begin
      low_bits_d = low_bits_q + 4'h1;
    end
    ln.edge_evt = (rx_prev_q != ln.rx_level) && (ln.rx_level == ln.polarity);
    ln.brk_evt = ln.brk_en && tick_en && tick_q == ASFC_TICKS_PER_BIT &&
                 (low_bits_q + 4'h1 == stop_bits);
    ln.berr_evt = tick_en && (ln.tx_level != ln.rx_level) &&
                  ((ln.berr_mode == ASFC_BIT_ERROR_MODE_T9 && tick_q == ASFC_TICK_EARLY) ||
                   (ln.berr_mode == ASFC_BIT_ERROR_MODE_T13 && tick_q == ASFC_TICK_LATE));
    ln.berr_val = ln.rx_level;
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_prev_q <= 1'b1;
      div_q <= 8'h00;
      tick_q <= 4'h0;
      low_bits_q <= 4'h0;
    end else begin
      rx_prev_q <= rx_prev_d;
      div_q <= div_d;
      tick_q <= tick_d;
      low_bits_q <= low_bits_d;
    end
  end
endmodule : asfc_line_mon

// File: tb/asfc_checker.sv
// Concurrent checks on the frame control block, seen only from its top ports.
// Assumes software writes byte lane zero and tracks the map bit as the design does.
module asfc_checker import asfc_pkg::*; #(
  parameter int TICK_DIV = ASFC_DEF_TICK_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic core_txd_i,
  input wire logic wait_mode_i,
  input wire logic txd_o,
  input wire logic core_rxd_o,
  input wire logic nine_bits_o,
  input wire logic wake_addr_mark_o,
  input wire logic idle_after_stop_o,
  input wire logic parity_enable_o,
  input wire logic parity_odd_o,
  input wire logic core_enable_o,
  input wire logic bit_error_irq_o,
  input wire logic break_irq_o,
  input wire logic rx_edge_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow of the software-visible control state
  // ----------------------------------------
  logic [7:0] fc_q, fc_d, ie_q, ie_d, idx;
  logic map_q, map_d, wr_s, fcw, ok_a;
  assign idx = paddr_i[9:2];
  assign ok_a = paddr_i[1:0] == 2'b00 && paddr_i[31:10] == '0;
  // Writes take effect at the access edge
  assign wr_s = psel_i && penable_i && pwrite_i && pstrb_i[0] && ok_a;
  assign fcw = wr_s && idx == ASFC_IDX_FRAME_CONTROL && !map_q;
  always_comb begin
    fc_d = fcw ? pwdata_i[7:0] : fc_q;
    ie_d = (wr_s && idx == ASFC_IDX_ALT_CONTROL_ONE && map_q) ? pwdata_i[7:0] : ie_q;
    map_d = (wr_s && idx == ASFC_IDX_STATUS_REGISTER_TWO) ? pwdata_i[ASFC_SR2_ALTERNATE_MAP_SELECT] : map_q;
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fc_q <= 8'h00;
      ie_q <= 8'h00;
      map_q <= 1'b0;
    end else begin
      fc_q <= fc_d;
      ie_q <= ie_d;
      map_q <= map_d;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_fc_length: assert property (
    fcw |=> nine_bits_o == fc_q[ASFC_FC_NINE] && wake_addr_mark_o == fc_q[ASFC_FC_WAKE])
    else $error("Length or wake output wrong after write");
  a_fc_idle: assert property (idle_after_stop_o == fc_q[ASFC_FC_ILT])
    else $error("Idle type output wrong");
  a_fc_parity: assert property ({parity_enable_o, parity_odd_o} == fc_q[1:0])
    else $error("Parity outputs wrong");
  a_loop_route: assert property (fc_q[ASFC_FC_LOOP] |-> core_rxd_o == core_txd_i)
    else $error("Receiver not fed from transmitter in loop");
  a_loop_txd: assert property (
    fc_q[ASFC_FC_LOOP] && !fc_q[ASFC_FC_RECEIVER_SOURCE] |-> txd_o) else $error("Pin not idle in loop");
  a_wait_stop: assert property (
    core_enable_o == !(fc_q[ASFC_FC_SWAI] && wait_mode_i)) else $error("Wait stop wrong");
  a_hidden_fc: assert property (
    wr_s && idx == ASFC_IDX_FRAME_CONTROL && map_q |=> $stable({nine_bits_o, parity_odd_o}))
    else $error("Hidden frame control changed");
  a_fc_read: assert property (
    psel_i && !penable_i && !pwrite_i && idx == ASFC_IDX_FRAME_CONTROL && !map_q && ok_a
    |=> prdata_o == {24'h0, fc_q}) else $error("Frame control read wrong");
  a_irq_enable: assert property (
    ({rx_edge_irq_o, bit_error_irq_o, break_irq_o} & ~{ie_q[7], ie_q[1:0]}) == 3'b000)
    else $error("Interrupt without enable");
  c_fc_write: cover property (fcw);
  c_edge_irq: cover property (map_q && rx_edge_irq_o);
  c_berr_irq: cover property (bit_error_irq_o);
  c_brk_irq: cover property (break_irq_o);
endmodule : asfc_checker
bind asfc_top asfc_checker #(.TICK_DIV(TICK_DIV)) u_chk (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .core_txd_i(core_txd_i), .wait_mode_i(wait_mode_i), .txd_o(txd_o), .core_rxd_o(core_rxd_o),
  .nine_bits_o(nine_bits_o), .wake_addr_mark_o(wake_addr_mark_o),
  .idle_after_stop_o(idle_after_stop_o), .parity_enable_o(parity_enable_o),
  .parity_odd_o(parity_odd_o), .core_enable_o(core_enable_o),
  .bit_error_irq_o(bit_error_irq_o), .break_irq_o(break_irq_o), .rx_edge_irq_o(rx_edge_irq_o));

// File: tb/asfc_node.sv
// Remote serial node on the receive pin.
// Assumes BIT_CLKS system clocks per bit; the line idles high as a pulled-up wire.
module asfc_node #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_o = 1'b1;
  // Levels change just after an edge and hold whole bit times
  task automatic hold(input logic lvl, input int n);
    rxd_o <= lvl;
    repeat (n * BIT_CLKS) @(posedge clk_sys_i);
  endtask : hold
endmodule : asfc_node

// File: tb/async_serial_frame_ctrl_status_test.sv
// Self-checking bench for the frame control and alternate status block.
// Assumes the remote node model on the receive pin and an APB master at 100 MHz.
module async_serial_frame_ctrl_status_test import asfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  localparam logic [7:0] FC = ASFC_IDX_FRAME_CONTROL;
  localparam logic [7:0] LES = ASFC_IDX_LINE_EVENT_STATUS;
  localparam logic [7:0] AC2 = ASFC_IDX_ALT_CONTROL_TWO;
  localparam logic [7:0] SR2 = ASFC_IDX_STATUS_REGISTER_TWO;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic core_txd_i = 1'b1, core_txd_oe_i = 1'b0, wait_mode_i = 1'b0;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o;
  logic [3:0] pstrb_i = 4'hF;
  logic pready_o, pslverr_o, rxd_i, txd_o, txd_oe_o, core_rxd_o, nine_bits_o, wake_addr_mark_o;
  logic idle_after_stop_o, parity_enable_o, parity_odd_o, core_enable_o;
  logic bit_error_irq_o, break_irq_o, rx_edge_irq_o;
  int fail_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] bad_addr = 32'h0;
  logic last_err;
  asfc_top #(.TICK_DIV(2)) dut (.clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i, .core_txd_i, .core_txd_oe_i,
    .wait_mode_i, .txd_o, .txd_oe_o, .core_rxd_o, .nine_bits_o, .wake_addr_mark_o,
    .idle_after_stop_o, .parity_enable_o, .parity_odd_o, .core_enable_o, .bit_error_irq_o,
    .break_irq_o, .rx_edge_irq_o);
  asfc_node #(.BIT_CLKS(BIT)) node (.clk_sys_i(clk_sys_i), .rxd_o(rxd_i));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard well above the roughly 1600 cycles of the full run
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end
  task automatic results;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; returns one edge after release so strobes never toggle in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] rd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {22'h0, idx, 2'b00} | bad_addr;
    pwdata_i <= {24'h0, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, idx, d, x);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] m, e);
    logic [31:0] x;
    apb(1'b0, idx, 8'h00, x);
    chk(nm, x & m, e);
  endtask : rdchk
  function automatic logic [31:0] fmt();
    return 32'({nine_bits_o, wake_addr_mark_o, idle_after_stop_o, parity_enable_o, parity_odd_o});
  endfunction : fmt
  task automatic t_reset;
    rdchk("fc reset", FC, ALL, 32'h0);
    rdchk("sr2 reset", SR2, ALL, 32'h0);
    rdchk("reserved", 8'h07, ALL, 32'h0);
  endtask : t_reset
  task automatic t_format;
    logic [7:0] p [4] = '{8'h1F, 8'h0A, 8'h15, 8'h00};
    foreach (p[i]) begin
      wr(FC, p[i]);
      rdchk("frame control", FC, ALL, 32'(p[i]));
      chk("format outputs", fmt(), 32'(p[i][4:0]));
    end
  endtask : t_format
  task automatic t_loop;
    core_txd_oe_i <= 1'b1;
    wr(FC, 8'h80);
    for (int v = 0; v < 2; v++) begin
      core_txd_i <= v[0];
      repeat (2) @(posedge clk_sys_i);
      chk("loop rx", 32'(core_rxd_o), 32'(v[0]));
      chk("loop tx", 32'(txd_o), 32'h1);
    end
    wr(FC, 8'hA0);
    core_txd_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("single wire rx", 32'(core_rxd_o), 32'h0);
    chk("single wire tx", 32'(txd_o), 32'h0);
    chk("tx enable", 32'(txd_oe_o), 32'h1);
    core_txd_i <= 1'b1;
    core_txd_oe_i <= 1'b0;
    wr(FC, 8'h00);
    node.hold(1'b0, 1);
    chk("pin rx", 32'(core_rxd_o), 32'h0);
    node.hold(1'b1, 1);
  endtask : t_loop
  task automatic t_wait;
    wr(FC, 8'h40);
    wait_mode_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("wait stop", 32'(core_enable_o), 32'h0);
    wr(FC, 8'h00);
    chk("wait run", 32'(core_enable_o), 32'h1);
    wait_mode_i <= 1'b0;
  endtask : t_wait
  task automatic t_map;
    wr(FC, 8'h15);
    wr(SR2, 8'h80);
    rdchk("map bit", SR2, ALL, 32'h80);
    wr(AC2, 8'h01);
    chk("fc hidden", fmt(), 32'h15);
    rdchk("alt ctl2", AC2, ALL, 32'h01);
    wr(SR2, 8'h00);
    rdchk("fc back", FC, ALL, 32'h15);
    chk("no slave error", 32'(last_err), 32'h0);
    bad_addr = 32'h00000401;
    rdchk("bad address", FC, ALL, 32'h0);
    chk("slave error", 32'(last_err), 32'h1);
    bad_addr = 32'h0;
    wr(SR2, 8'h80);
  endtask : t_map
  task automatic t_edge;
    wr(ASFC_IDX_ALT_CONTROL_ONE, 8'h83);
    wr(LES, 8'h00);
    rdchk("edge kept", LES, 32'h80, 32'h80);
    chk("edge irq", 32'(rx_edge_irq_o), 32'h1);
    wr(LES, 8'h80);
    rdchk("edge clear", LES, 32'h80, 32'h0);
    wr(SR2, 8'h90);
    wr(LES, 8'h80);
    node.hold(1'b0, 1);
    rdchk("fall pol1", LES, 32'h80, 32'h0);
    node.hold(1'b1, 1);
    rdchk("rise pol1", LES, 32'h80, 32'h80);
    wr(SR2, 8'h80);
    wr(LES, 8'h80);
  endtask : t_edge
  task automatic t_break;
    for (int e = 0; e < 2; e++) begin
      wr(AC2, 8'(e));
      node.hold(1'b0, 14);
      node.hold(1'b1, 2);
      rdchk("break flag", LES, 32'h1, 32'(e));
      chk("break irq", 32'(break_irq_o), 32'(e));
      wr(LES, 8'h81);
    end
    rdchk("break clear", LES, 32'h1, 32'h0);
  endtask : t_break
  task automatic t_berr;
    core_txd_oe_i <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(AC2, 8'(m << 1));
      core_txd_i <= 1'b0;
      repeat (BIT) @(posedge clk_sys_i);
      core_txd_i <= 1'b1;
      repeat (BIT) @(posedge clk_sys_i);
      rdchk("bit error", LES, 32'h7, (m == 0) ? 32'h0 : 32'h6);
      chk("bit error irq", 32'(bit_error_irq_o), 32'(m != 0));
      // Writing the value bit too must leave it alone
      wr(LES, 8'h06);
      rdchk("bit error clear", LES, 32'h6, (m == 0) ? 32'h0 : 32'h4);
    end
    node.hold(1'b0, 1);
    node.hold(1'b1, 1);
    rdchk("low seen", LES, 32'h7, 32'h2);
    core_txd_oe_i <= 1'b0;
  endtask : t_berr
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_format();
    t_loop();
    t_wait();
    t_map();
    t_edge();
    t_break();
    t_berr();
    results();
  end
endmodule : async_serial_frame_ctrl_status_test
